// ==== core/flash_ctrl_cfg.svh ====
// Offsets, fields, reset values and timing counts of the flash controller.
// Assumes inclusion by bare name from the package and the controller module.
`ifndef FLASH_CTRL_CFG_SVH
`define FLASH_CTRL_CFG_SVH
`define FC_BASE_ADDR 32'hffff_ff00
`define FC_OFF_MODE 8'h60
`define FC_OFF_CMD 8'h64
`define FC_OFF_STATUS 8'h68
`define FC_OFF_RSVD 8'h6c
`define FC_MODE_RESET 32'h0000_0000
`define FC_MODE_RDY_IE 0
`define FC_MODE_LOCK_ERROR_FLAG_IE 2
`define FC_MODE_PROG_ERROR_FLAG_IE 3
`define FC_MODE_SKIP_ERASE 7
`define FC_MODE_FWS_LO 8
`define FC_MODE_USEC_CYCLE_COUNT_LO 16
`define FC_ST_READY 0
`define FC_ST_LOCK_ERROR_FLAG 2
`define FC_ST_PROG_ERROR_FLAG 3
`define FC_ST_SECURITY 4
`define FC_ST_GP_LO 8
`define FC_ST_LOCKS_LO 16
`define FC_CMD_KEY 8'h5a
`define FC_CMD_PAGE_LO 8
`define FC_ERASE_TICKS 16'd10
`define FC_PROG_TICKS 16'd20
`define FC_NVM_TICKS 16'd8
`define FC_ERASE_ALL_TICKS 16'd40
`endif

// ==== core/flash_ctrl_pkg.sv ====
// Types shared by the flash command controller and its bench.
// Assumes flash_ctrl_cfg.svh sits beside it.
package flash_ctrl_pkg;
`include "flash_ctrl_cfg.svh"
    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_WRITE_PAGE = 4'b0001,
        CMD_SET_LOCK = 4'b0010,
        CMD_WRITE_PAGE_LOCK = 4'b0011,
        CMD_CLEAR_LOCK = 4'b0100,
        CMD_ERASE_ALL = 4'b1000,
        CMD_SET_GP_BIT = 4'b1011,
        CMD_CLEAR_GP_BIT = 4'b1101,
        CMD_SET_SECURITY = 4'b1111
    } command_code_t;
    typedef struct packed {
        logic [7:0] key;
        logic [5:0] unused_hi;
        logic [9:0] page_number;
        logic [3:0] unused_lo;
        logic [3:0] command_code;
    } cmd_word_t;
    typedef enum logic [2:0] {
        OP_IDLE, OP_ERASE_PAGE, OP_PROG_PAGE, OP_ERASE_ALL, OP_NVM_WRITE
    } flash_op_t;
    typedef struct packed {
        flash_op_t op;
        logic [9:0] page;
    } flash_act_t;
endpackage

// ==== core/embedded_flash_ctrl.sv ====
// Register interface and command sequencer of the embedded flash controller, APB slave.
// Assumes an APB master on CLK_SYS and a flash array that obeys the FLASH_ACT strobes.
//
// Functional notes
// - Mode, command, status at consecutive word offsets.
// - Mode bit 0 lets ready raise interrupt.
// - Mode bit 2 lets lock error interrupt.
// - Mode bit 3 lets programming error interrupt.
// - Bit 7 clear erases page before programming.
// - Wait-state field sets read/write access length.
// - Code 0000 does nothing, no error.
// - Code 0001 programs the selected page.
// - Code 0010 locks the page's region.
// - Code 0011 programs page, then locks region.
// - Code 0100 unlocks the page's region.
// - Code 1000 erases all unless any lock.
// - Code 1011 sets numbered general-purpose bit.
// - Code 1101 clears numbered general-purpose bit.
// - Code 1111 sets the security bit.
// - Other codes start nothing, flag programming error.
// - Page field bits 17:8, unused bits ignored.
// - Command needs key 0x5A in top byte.
// - Accept clears ready; completion sets it.
// - Lock error sticks until status read.
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"

module embedded_flash_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int LOCK_REGIONS = 16,
    parameter int GP_BITS = 2,
    parameter int REGION_SHIFT = 6,
    parameter logic [15:0] LOCK_INIT = 16'h0000
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    output flash_act_t FLASH_ACT,
    output logic [2:0] READ_CYCLES,
    output logic [2:0] WRITE_CYCLES,
    output logic [GP_BITS-1:0] GP_NONVOLATILE_BIT,
    output logic SECURITY_ACTIVE
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n_r;
    logic rst_n_r;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_n_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_n_r <= 1'b1;
            rst_n_r <= rst_meta_n_r;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] access_len(input logic [1:0] ws, input logic wr);
        logic [2:0] len;
        len = 3'(ws) + 3'd1;
        if (wr && ws != 2'd3) begin
            len = len + 3'd1;
        end
        return len;
    endfunction

    function automatic logic [3:0] region_of(input logic [9:0] page);
        return 4'(page >> REGION_SHIFT);
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [31:0] mode_r;
    logic ready_flag_r;
    logic lock_error_flag_r;
    logic prog_error_flag_r;
    logic security_r;
    logic [GP_BITS-1:0] gp_r;
    logic [LOCK_REGIONS-1:0] region_lock_state_r;
    logic [31:0] prdata_r;
    logic [31:0] status_word;
    logic hit_mode;
    logic hit_cmd;
    logic hit_status;
    logic access;
    logic wr_mode;
    logic wr_cmd;
    logic rd_status;
    cmd_word_t cmd;

    assign hit_mode = PADDR[7:0] == `FC_OFF_MODE;
    assign hit_cmd = PADDR[7:0] == `FC_OFF_CMD;
    assign hit_status = PADDR[7:0] == `FC_OFF_STATUS;
    assign access = PSEL && PENABLE && CLK_EN;
    assign wr_mode = access && PWRITE && hit_mode;
    assign wr_cmd = access && PWRITE && hit_cmd;
    assign rd_status = access && !PWRITE && hit_status;
    assign cmd = cmd_word_t'(PWDATA);

    // No wait states.
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE &&
        !(hit_mode || hit_cmd || hit_status || PADDR[7:0] == `FC_OFF_RSVD);

    always_comb begin
        status_word = 32'h0;
        status_word[`FC_ST_READY] = ready_flag_r;
        status_word[`FC_ST_LOCK_ERROR_FLAG] = lock_error_flag_r;
        status_word[`FC_ST_PROG_ERROR_FLAG] = prog_error_flag_r;
        status_word[`FC_ST_SECURITY] = security_r;
        status_word[`FC_ST_GP_LO +: GP_BITS] = gp_r;
        status_word[`FC_ST_LOCKS_LO +: LOCK_REGIONS] = region_lock_state_r;
    end

    // Read data is taken in the setup cycle, so it comes from a flop.
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata_r <= 32'h0;
        end else if (CLK_EN && PSEL && !PENABLE && !PWRITE) begin
            prdata_r <= hit_mode ? mode_r : (hit_status ? status_word : 32'h0);
        end
    end
    assign PRDATA = prdata_r;

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mode_r <= `FC_MODE_RESET;
        end else if (wr_mode) begin
            mode_r <= PWDATA & 32'h00ff_038d;
        end
    end

    logic skip_erase_before_prog;
    logic [1:0] wait_state_sel;
    logic [7:0] usec_cycle_count;
    assign skip_erase_before_prog = mode_r[`FC_MODE_SKIP_ERASE];
    assign wait_state_sel = mode_r[`FC_MODE_FWS_LO +: 2];
    assign usec_cycle_count = mode_r[`FC_MODE_USEC_CYCLE_COUNT_LO +: 8];

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            READ_CYCLES <= 3'd1;
            WRITE_CYCLES <= 3'd2;
        end else if (CLK_EN) begin
            READ_CYCLES <= access_len(wait_state_sel, 1'b0);
            WRITE_CYCLES <= access_len(wait_state_sel, 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    logic key_ok;
    logic code_known;
    logic start;
    logic [3:0] sel_region;

    assign key_ok = cmd.key == `FC_CMD_KEY;
    assign sel_region = region_of(cmd.page_number);
    assign code_known = cmd.command_code inside {CMD_NONE, CMD_WRITE_PAGE, CMD_SET_LOCK,
        CMD_WRITE_PAGE_LOCK, CMD_CLEAR_LOCK, CMD_ERASE_ALL, CMD_SET_GP_BIT,
        CMD_CLEAR_GP_BIT, CMD_SET_SECURITY};

    // Commands while busy are dropped.
    assign start = wr_cmd && key_ok && code_known && ready_flag_r &&
        cmd.command_code != CMD_NONE;

    logic page_locked;
    logic any_locked;
    assign page_locked = region_lock_state_r[sel_region];
    assign any_locked = |region_lock_state_r;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_ERASE, S_PROG, S_ERASE_ALL, S_NVM
    } seq_state_t;

    seq_state_t state_r;
    logic [3:0] op_code_r;
    logic [9:0] page_r;
    logic [7:0] usec_cnt_r;
    logic [15:0] phase_cnt_r;
    logic tick;
    logic phase_done;
    logic cancel;

    // Ticks pace every array phase.
    assign tick = (usec_cnt_r == 8'h0);
    assign phase_done = tick && (phase_cnt_r == 16'h0);

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            usec_cnt_r <= 8'h0;
        end else if (CLK_EN) begin
            if (state_r == S_IDLE || tick) begin
                usec_cnt_r <= usec_cycle_count;
            end else begin
                usec_cnt_r <= usec_cnt_r - 8'd1;
            end
        end
    end

    assign cancel = (cmd.command_code == CMD_ERASE_ALL) ? any_locked :
        (cmd.command_code inside {CMD_WRITE_PAGE, CMD_WRITE_PAGE_LOCK}) && page_locked;

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= S_IDLE;
            op_code_r <= 4'h0;
            page_r <= 10'h0;
            phase_cnt_r <= 16'h0;
        end else if (CLK_EN) begin
            case (state_r)
                S_IDLE: begin
                    if (start && !cancel) begin
                        op_code_r <= cmd.command_code;
                        page_r <= cmd.page_number;
                        case (cmd.command_code)
                            CMD_WRITE_PAGE, CMD_WRITE_PAGE_LOCK: begin
                                if (skip_erase_before_prog) begin
                                    state_r <= S_PROG;
                                    phase_cnt_r <= `FC_PROG_TICKS;
                                end else begin
                                    state_r <= S_ERASE;
                                    phase_cnt_r <= `FC_ERASE_TICKS;
                                end
                            end
                            CMD_ERASE_ALL: begin
                                state_r <= S_ERASE_ALL;
                                phase_cnt_r <= `FC_ERASE_ALL_TICKS;
                            end
                            default: begin
                                state_r <= S_NVM;
                                phase_cnt_r <= `FC_NVM_TICKS;
                            end
                        endcase
                    end
                end
                S_ERASE: begin
                    if (phase_done) begin
                        state_r <= S_PROG;
                        phase_cnt_r <= `FC_PROG_TICKS;
                    end else if (tick) begin
                        phase_cnt_r <= phase_cnt_r - 16'd1;
                    end
                end
                S_PROG: begin
                    if (phase_done) begin
                        if (op_code_r == CMD_WRITE_PAGE_LOCK) begin
                            state_r <= S_NVM;
                            phase_cnt_r <= `FC_NVM_TICKS;
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end else if (tick) begin
                        phase_cnt_r <= phase_cnt_r - 16'd1;
                    end
                end
                S_ERASE_ALL, S_NVM: begin
                    if (phase_done) begin
                        state_r <= S_IDLE;
                    end else if (tick) begin
                        phase_cnt_r <= phase_cnt_r - 16'd1;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    logic finish;
    assign finish = phase_done && (state_r == S_ERASE_ALL || state_r == S_NVM ||
        (state_r == S_PROG && op_code_r != CMD_WRITE_PAGE_LOCK));

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            FLASH_ACT <= '{op: OP_IDLE, page: 10'h0};
        end else if (CLK_EN) begin
            FLASH_ACT.page <= page_r;
            case (state_r)
                S_ERASE: FLASH_ACT.op <= OP_ERASE_PAGE;
                S_PROG: FLASH_ACT.op <= OP_PROG_PAGE;
                S_ERASE_ALL: FLASH_ACT.op <= OP_ERASE_ALL;
                S_NVM: FLASH_ACT.op <= OP_NVM_WRITE;
                default: FLASH_ACT.op <= OP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Non-volatile bits
    // ------------------------------------------------------------
    logic nvm_done;
    logic [3:0] page_region;
    assign nvm_done = CLK_EN && state_r == S_NVM && phase_done;
    assign page_region = region_of(page_r);

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            region_lock_state_r <= LOCK_INIT[LOCK_REGIONS-1:0];
        end else if (nvm_done) begin
            case (op_code_r)
                CMD_SET_LOCK, CMD_WRITE_PAGE_LOCK: begin
                    region_lock_state_r[page_region] <= 1'b1;
                end
                CMD_CLEAR_LOCK: region_lock_state_r[page_region] <= 1'b0;
                default: ;
            endcase
        end
    end

    // Bit numbers past GP_BITS have no effect.
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            gp_r <= '0;
            security_r <= 1'b0;
        end else if (nvm_done) begin
            if ((op_code_r == CMD_SET_GP_BIT || op_code_r == CMD_CLEAR_GP_BIT) &&
                page_r < 10'(GP_BITS)) begin
                gp_r[page_r[$clog2(GP_BITS)-1:0]] <= op_code_r == CMD_SET_GP_BIT;
            end
            if (op_code_r == CMD_SET_SECURITY) begin
                security_r <= 1'b1;
            end
        end
    end
    assign GP_NONVOLATILE_BIT = gp_r;
    assign SECURITY_ACTIVE = security_r;

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ready_flag_r <= 1'b1;
        end else if (CLK_EN) begin
            if (start && !cancel) begin
                ready_flag_r <= 1'b0;
            end else if (finish) begin
                ready_flag_r <= 1'b1;
            end
        end
    end

    // A status read clears errors; a same-cycle error wins.
    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            lock_error_flag_r <= 1'b0;
        end else if (start && cancel) begin
            lock_error_flag_r <= 1'b1;
        end else if (rd_status) begin
            lock_error_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prog_error_flag_r <= 1'b0;
        end else if (wr_cmd && (!key_ok || !code_known)) begin
            prog_error_flag_r <= 1'b1;
        end else if (rd_status) begin
            prog_error_flag_r <= 1'b0;
        end
    end

    assign IRQ = (ready_flag_r && mode_r[`FC_MODE_RDY_IE]) ||
        (lock_error_flag_r && mode_r[`FC_MODE_LOCK_ERROR_FLAG_IE]) ||
        (prog_error_flag_r && mode_r[`FC_MODE_PROG_ERROR_FLAG_IE]);

endmodule

// ==== bench/flash_ctrl_checker.sv ====
// Concurrent checks on the ports of the flash command controller.
// Assumes the bind below.
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
module flash_ctrl_checker
    import flash_ctrl_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire flash_act_t FLASH_ACT,
    input wire logic [2:0] READ_CYCLES,
    input wire logic [2:0] WRITE_CYCLES
);
    logic acc, mapped, wr_mode, wr_cmd, key_ok, code_ok, prog_start;
    logic [31:0] mode_r;
    logic [1:0] age_r;
    logic [2:0] rd_exp, wr_exp;
    flash_op_t last_r, prev_r;
    assign acc = PSEL && PENABLE && CLK_EN;
    assign mapped = PADDR[7:0] inside {8'h60, 8'h64, 8'h68, 8'h6c};
    assign wr_mode = acc && PWRITE && PADDR[7:0] == `FC_OFF_MODE;
    assign wr_cmd = acc && PWRITE && PADDR[7:0] == `FC_OFF_CMD;
    assign key_ok = PWDATA[31:24] == `FC_CMD_KEY;
    assign code_ok = PWDATA[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hd, 4'hf};
    assign prog_start = FLASH_ACT.op == OP_PROG_PAGE && prev_r != OP_PROG_PAGE;
    assign rd_exp = {1'b0, mode_r[9:8]} + 3'h1;
    assign wr_exp = (mode_r[9:8] == 2'h3) ? 3'h4 : {1'b0, mode_r[9:8]} + 3'h2;
    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_r <= 32'h0;
            age_r <= 2'h0;
        end else if (wr_mode) begin
            mode_r <= PWDATA & 32'h00ff_038d;
            age_r <= 2'h0;
        end else if (CLK_EN && age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    // History restarts at each command write, so an old erase excuses nothing.
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            last_r <= OP_IDLE;
            prev_r <= OP_IDLE;
        end else begin
            prev_r <= FLASH_ACT.op;
            if (wr_cmd) begin
                last_r <= OP_IDLE;
            end else if (FLASH_ACT.op != OP_IDLE) begin
                last_r <= FLASH_ACT.op;
            end
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    a_pready_high: assert property (PSEL |-> PREADY)
        else $error("pready low while selected");
    a_slverr_unmapped: assert property (PSEL && PENABLE && !mapped |-> PSLVERR)
        else $error("unmapped access without slave error");
    a_slverr_mapped: assert property (PSEL && PENABLE && mapped |-> !PSLVERR)
        else $error("mapped access gave slave error");
    a_read_len: assert property (age_r == 2'h3 |-> READ_CYCLES == rd_exp)
        else $error("read access length wrong");
    a_write_len: assert property (age_r == 2'h3 |-> WRITE_CYCLES == wr_exp)
        else $error("write access length wrong");
    a_irq_masked: assert property (!(mode_r[0] || mode_r[2] || mode_r[3]) |-> !IRQ)
        else $error("interrupt with all enables clear");
    a_erase_first: assert property (prog_start && !mode_r[7] |-> last_r == OP_ERASE_PAGE)
        else $error("program without preceding erase");
    a_no_erase: assert property (prog_start && mode_r[7] |-> last_r == OP_IDLE)
        else $error("erase done although skipped");
    a_badkey_idle: assert property (wr_cmd && !key_ok && FLASH_ACT.op == OP_IDLE
        |=> (FLASH_ACT.op == OP_IDLE) [*6]) else $error("bad key started an operation");
    a_badcode_idle: assert property (wr_cmd && key_ok && !code_ok &&
        FLASH_ACT.op == OP_IDLE |=> (FLASH_ACT.op == OP_IDLE) [*6])
        else $error("reserved code started an operation");
endmodule

bind embedded_flash_ctrl flash_ctrl_checker u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .FLASH_ACT(FLASH_ACT),
    .READ_CYCLES(READ_CYCLES), .WRITE_CYCLES(WRITE_CYCLES));

// ==== bench/apb_host_model.sv ====
// Host processor model: an APB master issuing register and command transfers.
// Assumes the bench calls its tasks by hierarchy.
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
module apb_host_model (
    input wire logic clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] off, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= `FC_BASE_ADDR | {24'h0, off};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // NVM bits use 1 us of cycles, array work 1.5 us rounded up; never zero.
    task automatic command(input logic [7:0] key, input logic [3:0] code,
                           input logic [9:0] page, input logic [9:0] mode_lo,
                           input logic [5:0] junk);
        logic [31:0] q;
        logic e;
        logic [7:0] usec;
        usec = (code inside {4'h2, 4'h4, 4'hb, 4'hd, 4'hf}) ? 8'd100 : 8'd150;
        xfer(1'b1, `FC_OFF_MODE, {8'h0, usec, 6'h0, mode_lo}, q, e);
        xfer(1'b1, `FC_OFF_CMD, {key, junk, page, 4'h0, code}, q, e);
    endtask
    task automatic wait_ready(output logic [31:0] st);
        logic e;
        st = 32'h0;
        for (int i = 0; i < 5000 && st[0] !== 1'b1; i++) begin
            xfer(1'b0, `FC_OFF_STATUS, 32'h0, st, e);
        end
    endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench of the flash command controller.
// Assumes the package, the host model and the checker are compiled before it.
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_top
    import flash_ctrl_pkg::*;
;
    logic clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, irq, sec, err;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [2:0] rd_cyc, wr_cyc;
    logic [1:0] gp;
    logic [9:0] pg;
    flash_act_t act, ea;
    flash_op_t op_prev = OP_IDLE;
    flash_act_t exp_q[$];
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    embedded_flash_ctrl DUT (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .FLASH_ACT(act), .READ_CYCLES(rd_cyc),
        .WRITE_CYCLES(wr_cyc), .GP_NONVOLATILE_BIT(gp), .SECURITY_ACTIVE(sec));
    apb_host_model host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    always #5 clk = ~clk;
    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (act.op != op_prev && act.op != OP_IDLE) begin
            ea = (exp_q.size() > 0) ? exp_q.pop_front() : '{op: OP_IDLE, page: 10'h0};
            `CHK("array op", ea.op, act.op)
            if (ea.op inside {OP_ERASE_PAGE, OP_PROG_PAGE}) `CHK("page", ea.page, act.page)
        end
        op_prev = act.op;
    end
    function automatic void ex(flash_op_t o, logic [9:0] p);
        exp_q.push_back('{op: o, page: p});
    endfunction
    task automatic rd(input logic [7:0] off);
        host.xfer(1'b0, off, 32'h0, q, err);
    endtask
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        host.xfer(1'b1, off, d, q, err);
    endtask
    task automatic c(logic [7:0] k, logic [3:0] cd, logic [9:0] p, logic [9:0] m);
        host.command(k, cd, p, m, 6'h0);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        void'($urandom(32'h42d067d2));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`FC_OFF_MODE); `CHK("mode reset", 32'h0, q)
        `CHK("read len", 3'h1, rd_cyc)
        rd(`FC_OFF_STATUS); `CHK("ready reset", 1'b1, q[0])
        rd(8'h70); `CHK("unmapped", 1'b1, err)
        rd(`FC_OFF_RSVD); `CHK("reserved", 32'h0, q)
        wr(`FC_OFF_MODE, 32'hffff_ffff); rd(`FC_OFF_MODE); `CHK("mode rw", 32'h00ff_038d, q)
        for (int f = 0; f < 4; f++) begin
            wr(`FC_OFF_MODE, {22'h0, f[1:0], 8'h0});
            repeat (3) @(posedge clk);
            `CHK("read len", 3'(f + 1), rd_cyc)
            `CHK("write len", (f == 3) ? 3'h4 : 3'(f + 2), wr_cyc)
        end
        @(posedge clk) clk_en <= 1'b0;
        wr(`FC_OFF_MODE, 32'h0);
        @(posedge clk) clk_en <= 1'b1;
        rd(`FC_OFF_MODE); `CHK("frozen mode", 2'h3, q[9:8])
        c(8'ha5, CMD_WRITE_PAGE, 10'h5, 10'h008); repeat (8) @(posedge clk);
        `CHK("prog irq", 1'b1, irq)
        rd(`FC_OFF_STATUS); `CHK("bad key", 1'b1, q[3])
        @(posedge clk); `CHK("irq cleared", 1'b0, irq)
        for (int i = 0; i < 16; i++) begin
            if (!(i inside {1, 2, 3, 4, 8, 11, 13, 15})) begin
                c(8'h5a, 4'(i), 10'h0, 10'h0); rd(`FC_OFF_STATUS);
                `CHK("code error", (i != 0), q[3])
            end
        end
        pg = {4'h0, 6'($urandom())};
        ex(OP_ERASE_PAGE, pg); ex(OP_PROG_PAGE, pg);
        host.command(8'h5a, CMD_WRITE_PAGE, pg, 10'h001, 6'($urandom()));
        rd(`FC_OFF_STATUS); `CHK("busy", 1'b0, q[0])
        host.wait_ready(q); `CHK("ready irq", 1'b1, irq)
        ex(OP_PROG_PAGE, 10'h3c5);
        host.command(8'h5a, CMD_WRITE_PAGE, 10'h3c5, 10'h080, 6'h3f);
        host.wait_ready(q); `CHK("ready masked", 1'b0, irq)
        ex(OP_NVM_WRITE, 10'h0); c(8'h5a, CMD_SET_LOCK, 10'd70, 10'h004);
        c(8'h5a, CMD_SET_GP_BIT, 10'h0, 10'h004);
        host.wait_ready(q); `CHK("lock set", 1'b1, q[17])
        `CHK("busy dropped", 2'h0, q[9:8])
        c(8'h5a, CMD_WRITE_PAGE, 10'd64, 10'h004); repeat (4) @(posedge clk);
        `CHK("lock irq", 1'b1, irq)
        rd(`FC_OFF_STATUS); `CHK("lock error", 2'h3, {q[2], q[0]})
        rd(`FC_OFF_STATUS); `CHK("lock error clr", 1'b0, q[2])
        c(8'h5a, CMD_ERASE_ALL, 10'h0, 10'h0);
        rd(`FC_OFF_STATUS); `CHK("erase all locked", 1'b1, q[2])
        ex(OP_PROG_PAGE, 10'h5); ex(OP_NVM_WRITE, 10'h0);
        c(8'h5a, CMD_WRITE_PAGE_LOCK, 10'h5, 10'h080);
        host.wait_ready(q); `CHK("page lock", 2'h3, q[17:16])
        ex(OP_NVM_WRITE, 10'h0); c(8'h5a, CMD_CLEAR_LOCK, 10'd70, 10'h0); host.wait_ready(q);
        ex(OP_NVM_WRITE, 10'h0); c(8'h5a, CMD_CLEAR_LOCK, 10'h5, 10'h0); host.wait_ready(q);
        `CHK("unlocked", 16'h0, q[31:16])
        ex(OP_ERASE_ALL, 10'h0); c(8'h5a, CMD_ERASE_ALL, 10'h3ff, 10'h0);
        host.wait_ready(q); `CHK("erase all", 1'b0, q[2])
        ex(OP_NVM_WRITE, 10'h0); c(8'h5a, CMD_SET_GP_BIT, 10'h1, 10'h0); host.wait_ready(q);
        `CHK("gp set", 2'h2, gp)
        ex(OP_NVM_WRITE, 10'h0); c(8'h5a, CMD_CLEAR_GP_BIT, 10'h1, 10'h0); host.wait_ready(q);
        `CHK("gp clear", 2'h0, q[9:8])
        ex(OP_NVM_WRITE, 10'h0); c(8'h5a, CMD_SET_SECURITY, 10'h3ff, 10'h0); host.wait_ready(q);
        `CHK("security", 2'h3, {sec, q[4]})
        `CHK("pending ops", 0, exp_q.size())
        give_verdict();
    end
endmodule
